// ---- eal_cfg.svh ----
`ifndef EAL_CFG_SVH
`define EAL_CFG_SVH
// ==========================================================
// register offsets (9-bit register file addresses)
`define EAL_ADDR_LVR_OVERRIDE 9'h109
`define EAL_ADDR_CONTROL 9'h18D
`define EAL_ADDR_ACCESS_KEY 9'h18E
`define EAL_ADDR_WRITE_DATA 9'h18F
`define EAL_ADDR_PTR_LOW 9'h185
`define EAL_ADDR_PTR_HIGH 9'h186
// ==========================================================
// key values and reset values
`define EAL_ACCESS_KEY 8'hE2
`define EAL_LVR_OFF_KEY 8'h37
`define EAL_RESET_BYTE 8'h00
// ==========================================================
// control register fields
`define EAL_CTL_TO_BIT 7
`define EAL_CTL_SEL_HI 1
`define EAL_CTL_SEL_LO 0
// ==========================================================
// configuration word fields (14-bit words, bits 13..0)
`define EAL_CFGH_PROTECT 13
`define EAL_CFGH_XRST 12
`define EAL_CFGH_LVR_HI 11
`define EAL_CFGH_LVR_LO 10
`define EAL_CFGH_WDT_HI 9
`define EAL_CFGH_WDT_LO 8
`define EAL_CFGL_LOCK 13
`define EAL_CFGL_SIZE_HI 12
`define EAL_CFGL_SIZE_LO 9
`define EAL_CFG_RESET 14'h0000
// library region: top 0xFFF, 0001 -> E00, each step 128 words
`define EAL_LIB_BASE_MIN 12'hE00
`define EAL_LIB_STEP 12'h080
// ==========================================================
// timing: time-outs in microseconds at 125 MHz
`define EAL_CLK_MHZ 125
`define EAL_TO1_US 900
`define EAL_TO2_US 3600
`define EAL_TO3_US 7200
`define EAL_TO1_CYC (`EAL_TO1_US * `EAL_CLK_MHZ)
`define EAL_TO2_CYC (`EAL_TO2_US * `EAL_CLK_MHZ)
`define EAL_TO3_CYC (`EAL_TO3_US * `EAL_CLK_MHZ)
`endif

// ---- eal_pkg.sv ----
package eal_pkg;
    // write engine states
    typedef enum logic [1:0] {
        EAL_IDLE,
        EAL_PROG,
        EAL_DONE
    } eal_wr_state_e;
    // reset threshold and detect level selections
    typedef enum logic [1:0] {
        EAL_LV_2V4,
        EAL_LV_2V5,
        EAL_LV_3V2,
        EAL_LV_3V7
    } eal_level_e;
    typedef logic [6:0] eal_addr_t;
    typedef logic [7:0] eal_byte_t;
endpackage

// ---- eal_array_if.sv ----
// ==========================================================
// path between the access engine and the byte array
interface eal_array_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic we;
    modport engine (output addr, output wdata, output we, input rdata);
    modport array (input addr, input wdata, input we, output rdata);
endinterface

// ---- eal_array.sv ----
// ==========================================================
// 128-byte data array, one byte per index
module eal_array (
    input wire logic clk_i,
    input wire logic nrst_i,
    eal_array_if.array mem
);
    logic [7:0] mem_reg [0:127];
    integer i;

    // byte write; contents cleared at reset stand in for erased cells
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (i = 0; i < 128; i = i + 1) begin
                mem_reg[i] <= 8'h00;
            end
        end else if (mem.we) begin
            mem_reg[mem.addr] <= mem.wdata;
        end
    end

    // each byte read on its own index
    assign mem.rdata = mem_reg[mem.addr];
endmodule

// ---- eal_cfg_decode.sv ----
`include "eal_cfg.svh"
// ==========================================================
// combinational decode of the two configuration words
module eal_cfg_decode (
    input wire logic [13:0] cfg_low_i,
    input wire logic [13:0] cfg_high_i,
    input wire logic [1:0] lvd_sel_i,
    output logic code_protect_o,
    output logic ext_reset_en_o,
    output eal_pkg::eal_level_e lvr_level_o,
    output logic lvd_active_o,
    output eal_pkg::eal_level_e lvd_level_o,
    output logic wdt_run_en_o,
    output logic wdt_idle_en_o,
    output logic lib_lock_o,
    output logic [11:0] lib_base_o
);
    logic [3:0] size;

    // protection, pin reset and watchdog bits
    always_comb begin
        code_protect_o = cfg_high_i[`EAL_CFGH_PROTECT];
        ext_reset_en_o = cfg_high_i[`EAL_CFGH_XRST];
        wdt_run_en_o = cfg_high_i[`EAL_CFGH_WDT_HI];
        wdt_idle_en_o = cfg_high_i[`EAL_CFGH_WDT_HI]
                        & cfg_high_i[`EAL_CFGH_WDT_LO];
    end

    // reset threshold; only the lowest keeps detection
    always_comb begin
        case (cfg_high_i[`EAL_CFGH_LVR_HI:`EAL_CFGH_LVR_LO])
            2'h3: lvr_level_o = eal_pkg::EAL_LV_3V7;
            2'h2: lvr_level_o = eal_pkg::EAL_LV_3V2;
            2'h1: lvr_level_o = eal_pkg::EAL_LV_2V5;
            default: lvr_level_o = eal_pkg::EAL_LV_2V4;
        endcase
        lvd_active_o = (lvr_level_o == eal_pkg::EAL_LV_2V4);
        if (lvd_sel_i[1]) begin
            lvd_level_o = eal_pkg::EAL_LV_3V7;
        end else if (lvd_sel_i[0]) begin
            lvd_level_o = eal_pkg::EAL_LV_2V5;
        end else begin
            lvd_level_o = eal_pkg::EAL_LV_3V2;
        end
    end

    // library base: E00 for size 1, 128 words lower per step
    always_comb begin
        size = cfg_low_i[`EAL_CFGL_SIZE_HI:`EAL_CFGL_SIZE_LO];
        lib_lock_o = cfg_low_i[`EAL_CFGL_LOCK] && size != 4'h0;
        lib_base_o = 12'(`EAL_LIB_BASE_MIN
                     - 12'(size - 4'h1) * `EAL_LIB_STEP);
    end
endmodule

// ---- eal_top.sv ----
`include "eal_cfg.svh"
// Operation
// - writing E2 to the access key enables access; other values disable
// - 128 data bytes, each read and written on its own
// - with access enabled, table reads return the pointed data byte
// - write-data register write with access enabled starts a byte write
// - writing 37 to override turns low-voltage reset off; else on
// - time-out select: off, 0.9 ms, 3.6 ms or 7.2 ms
// - control bit 7 is a read-only flag set on write time-out
// - two configuration words, loaded by the writer, fix reset state
// - high word bit 12 enables pin reset on port A bit 7
// - high word bits 11:10 select the low-voltage reset threshold
// - at 2.4 V, detection select gives 3.2, 2.5 or 3.7 V
// - high word bits 9:8 set watchdog reset: always, run-only, off
// - low word bit 13 enables the library page lock
// - locked region runs down from FFF; reads inside are refused while access is disabled
// - protect bits clear only at reset or after their program area was erased
module eal_top (
    input wire logic clk_i,
    input wire logic nrst_i,
    // cpu register port
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // table read request from the cpu
    input wire logic tab_req_i,
    input wire logic tab_high_i,
    input wire logic [11:0] prog_addr_i,
    input wire logic [15:0] prog_data_i,
    input wire logic user_read_i,
    output logic [7:0] tab_data_o,
    output logic tab_valid_o,
    output logic tab_refused_o,
    // array programming completion from the cell timer
    input wire logic prog_done_i,
    output logic cpu_hold_o,
    // configuration words from the information area
    input wire logic cfg_load_i,
    input wire logic [13:0] cfg_low_i,
    input wire logic [13:0] cfg_high_i,
    input wire logic user_erased_i,
    input wire logic lib_erased_i,
    input wire logic [1:0] lvd_sel_i,
    // decoded options
    output logic lvr_enable_o,
    output logic code_protect_o,
    output logic ext_reset_en_o,
    output logic [1:0] lvr_level_o,
    output logic lvd_active_o,
    output logic [1:0] lvd_level_o,
    output logic wdt_run_en_o,
    output logic wdt_idle_en_o,
    output logic lib_lock_o
);
    // ==========================================================
    // registers
    logic access_en_reg;
    logic lvr_off_reg;
    logic [1:0] to_sel_reg;
    logic to_flag_reg;
    logic [7:0] ptr_low_reg;
    logic [7:0] ptr_high_reg;
    logic [13:0] cfg_low_reg;
    logic [13:0] cfg_high_reg;
    logic [20:0] to_cnt_reg;
    logic [20:0] to_limit_reg;
    logic [7:0] wbyte_reg;
    logic prog_done_s1_reg;
    logic prog_done_reg;
    eal_pkg::eal_wr_state_e wr_state_reg;
    logic code_protect_w;
    logic ext_reset_w;
    eal_pkg::eal_level_e lvr_level_w;
    eal_pkg::eal_level_e lvd_level_w;
    logic lvd_active_w;
    logic wdt_run_w;
    logic wdt_idle_w;
    logic lib_lock_w;
    logic [11:0] lib_base_w;
    logic wr_start;
    logic in_lib;

    eal_array_if mem ();

    eal_array u_array (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .mem(mem.array)
    );

    eal_cfg_decode u_dec (
        .cfg_low_i(cfg_low_reg),
        .cfg_high_i(cfg_high_reg),
        .lvd_sel_i(lvd_sel_i),
        .code_protect_o(code_protect_w),
        .ext_reset_en_o(ext_reset_w),
        .lvr_level_o(lvr_level_w),
        .lvd_active_o(lvd_active_w),
        .lvd_level_o(lvd_level_w),
        .wdt_run_en_o(wdt_run_w),
        .wdt_idle_en_o(wdt_idle_w),
        .lib_lock_o(lib_lock_w),
        .lib_base_o(lib_base_w)
    );

    // selected time-out in cycles; zero means disabled
    function automatic logic [20:0] to_cycles(input logic [1:0] sel);
        case (sel)
            2'h1: to_cycles = 21'(`EAL_TO1_CYC);
            2'h2: to_cycles = 21'(`EAL_TO2_CYC);
            2'h3: to_cycles = 21'(`EAL_TO3_CYC);
            default: to_cycles = 21'h000000;
        endcase
    endfunction

    // ==========================================================
    // array path: address from low seven pointer bits
    assign mem.addr = ptr_low_reg[6:0];
    assign mem.wdata = wbyte_reg;
    assign mem.we = (wr_state_reg == eal_pkg::EAL_PROG) && prog_done_reg;
    assign wr_start = reg_we_i && reg_addr_i == `EAL_ADDR_WRITE_DATA
                      && access_en_reg && wr_state_reg == eal_pkg::EAL_IDLE;
    assign in_lib = lib_lock_w && prog_addr_i >= lib_base_w;

    // access key: only the exact key opens access
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            access_en_reg <= 1'b0;
        end else if (reg_we_i && reg_addr_i == `EAL_ADDR_ACCESS_KEY) begin
            access_en_reg <= reg_wdata_i == `EAL_ACCESS_KEY;
        end
    end

    // low-voltage reset override; any other value re-enables reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvr_off_reg <= 1'b0;
        end else if (reg_we_i && reg_addr_i == `EAL_ADDR_LVR_OVERRIDE) begin
            lvr_off_reg <= reg_wdata_i == `EAL_LVR_OFF_KEY;
        end
    end

    // pointer bytes and time-out select
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_low_reg <= `EAL_RESET_BYTE;
            ptr_high_reg <= `EAL_RESET_BYTE;
            to_sel_reg <= 2'h0;
        end else if (reg_we_i) begin
            if (reg_addr_i == `EAL_ADDR_PTR_LOW) begin
                ptr_low_reg <= reg_wdata_i;
            end else if (reg_addr_i == `EAL_ADDR_PTR_HIGH) begin
                ptr_high_reg <= reg_wdata_i;
            end else if (reg_addr_i == `EAL_ADDR_CONTROL) begin
                to_sel_reg <= reg_wdata_i[`EAL_CTL_SEL_HI:`EAL_CTL_SEL_LO];
            end
        end
    end

    // completion pulse comes from the analog cell timer: synchronise
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prog_done_s1_reg <= 1'b0;
            prog_done_reg <= 1'b0;
        end else begin
            prog_done_s1_reg <= prog_done_i;
            prog_done_reg <= prog_done_s1_reg;
        end
    end

    // write engine: hold cpu until programming ends or time-out
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_state_reg <= eal_pkg::EAL_IDLE;
            to_cnt_reg <= 21'h000000;
            to_limit_reg <= 21'h000000;
            wbyte_reg <= `EAL_RESET_BYTE;
            to_flag_reg <= 1'b0;
        end else begin
            case (wr_state_reg)
                eal_pkg::EAL_IDLE: begin
                    if (wr_start) begin
                        wbyte_reg <= reg_wdata_i;
                        to_limit_reg <= to_cycles(to_sel_reg);
                        to_cnt_reg <= 21'h000000;
                        to_flag_reg <= 1'b0;
                        wr_state_reg <= eal_pkg::EAL_PROG;
                    end
                end
                eal_pkg::EAL_PROG: begin
                    to_cnt_reg <= 21'(to_cnt_reg + 21'h000001);
                    if (prog_done_reg) begin
                        wr_state_reg <= eal_pkg::EAL_DONE;
                    end else if (to_limit_reg != 21'h000000
                                 && to_cnt_reg + 21'h000001
                                 >= to_limit_reg) begin
                        to_flag_reg <= 1'b1;
                        wr_state_reg <= eal_pkg::EAL_DONE;
                    end
                end
                default: wr_state_reg <= eal_pkg::EAL_IDLE;
            endcase
        end
    end

    // configuration words latched on each load pulse; protect bits sticky
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_low_reg <= `EAL_CFG_RESET;
            cfg_high_reg <= `EAL_CFG_RESET;
        end else if (cfg_load_i) begin
            cfg_low_reg <= cfg_low_i;
            cfg_high_reg <= cfg_high_i;
            if (cfg_high_reg[`EAL_CFGH_PROTECT] && !user_erased_i) begin
                cfg_high_reg[`EAL_CFGH_PROTECT] <= 1'b1;
            end
            if (cfg_low_reg[`EAL_CFGL_LOCK] && !lib_erased_i) begin
                cfg_low_reg[`EAL_CFGL_LOCK] <= 1'b1;
            end
        end
    end

    // table read answer one cycle after the request
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tab_data_o <= `EAL_RESET_BYTE;
            tab_valid_o <= 1'b0;
            tab_refused_o <= 1'b0;
        end else begin
            tab_valid_o <= tab_req_i;
            tab_refused_o <= 1'b0;
            if (!tab_req_i) begin
                tab_data_o <= tab_data_o;
            end else if (access_en_reg) begin
                tab_data_o <= mem.rdata;
            end else if (in_lib || (code_protect_w && user_read_i)) begin
                tab_data_o <= `EAL_RESET_BYTE;
                tab_refused_o <= 1'b1;
            end else begin
                tab_data_o <= tab_high_i ? prog_data_i[15:8]
                                         : prog_data_i[7:0];
            end
        end
    end

    // register read-back; write-only registers read as zero
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= `EAL_RESET_BYTE;
        end else if (reg_re_i && reg_addr_i == `EAL_ADDR_CONTROL) begin
            reg_rdata_o <= {to_flag_reg, 5'h00, to_sel_reg};
        end else if (reg_re_i && reg_addr_i == `EAL_ADDR_PTR_LOW) begin
            reg_rdata_o <= ptr_low_reg;
        end else if (reg_re_i && reg_addr_i == `EAL_ADDR_PTR_HIGH) begin
            reg_rdata_o <= ptr_high_reg;
        end else begin
            reg_rdata_o <= `EAL_RESET_BYTE;
        end
    end

    // decoded options registered for clean outputs
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cpu_hold_o <= 1'b0;
            lvr_enable_o <= 1'b1;
            code_protect_o <= 1'b0;
            ext_reset_en_o <= 1'b0;
            lvr_level_o <= 2'h0;
            lvd_active_o <= 1'b0;
            lvd_level_o <= 2'h0;
            wdt_run_en_o <= 1'b0;
            wdt_idle_en_o <= 1'b0;
            lib_lock_o <= 1'b0;
        end else begin
            cpu_hold_o <= wr_start
                          || (wr_state_reg == eal_pkg::EAL_PROG
                              && !prog_done_reg);
            lvr_enable_o <= !lvr_off_reg;
            code_protect_o <= code_protect_w;
            ext_reset_en_o <= ext_reset_w;
            lvr_level_o <= lvr_level_w;
            lvd_active_o <= lvd_active_w;
            lvd_level_o <= lvd_level_w;
            wdt_run_en_o <= wdt_run_w;
            wdt_idle_en_o <= wdt_idle_w;
            lib_lock_o <= lib_lock_w;
        end
    end

    // ==========================================================
    // checks
    sequence s_key_write;
        reg_we_i && reg_addr_i == `EAL_ADDR_ACCESS_KEY;
    endsequence

    a_key_opens: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_key_write |=> access_en_reg == $past(reg_wdata_i == 8'hE2))
        else $error("access enable does not follow key");
    a_lvr_follow: assert property (@(posedge clk_i) disable iff (!nrst_i)
        reg_we_i && reg_addr_i == `EAL_ADDR_LVR_OVERRIDE
        |-> ##3 lvr_enable_o == ($past(reg_wdata_i, 3) != 8'h37))
        else $error("override output wrong");
    a_write_start: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_start |=> wr_state_reg == eal_pkg::EAL_PROG)
        else $error("write not started");
    a_flag_expiry: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(to_flag_reg) |-> $past(wr_state_reg == eal_pkg::EAL_PROG)
                              && !$past(prog_done_reg))
        else $error("flag set without expiry");
    a_hold_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wr_start |=> cpu_hold_o)
        else $error("cpu not held");
    a_ctl_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        reg_re_i && reg_addr_i == `EAL_ADDR_CONTROL
        |=> reg_rdata_o[7] == $past(to_flag_reg))
        else $error("flag read-back wrong");
    a_lib_refuse: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tab_req_i && !access_en_reg && in_lib |=> tab_refused_o)
        else $error("library read allowed");
    a_eep_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tab_req_i && access_en_reg
        |=> tab_data_o == $past(mem.rdata) && tab_valid_o)
        else $error("data byte not returned");
endmodule

// ---- eal_cpu_model.sv ----
// ==========================================================
// cpu core model: register writes, reads and table reads
module eal_cpu_model (
    input wire logic clk_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic [7:0] tab_data_i,
    input wire logic tab_valid_i,
    input wire logic tab_refused_i,
    output logic [8:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_we_o,
    output logic reg_re_o,
    output logic tab_req_o,
    output logic tab_high_o,
    output logic [11:0] prog_addr_o,
    output logic user_read_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        reg_addr_o = 9'h000;
        reg_wdata_o = 8'h00;
        reg_we_o = 1'b0;
        reg_re_o = 1'b0;
        tab_req_o = 1'b0;
        tab_high_o = 1'b0;
        prog_addr_o = 12'h000;
        user_read_o = 1'b0;
    end
    // one write strobe, taken at the rising edge in between
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_we_o = 1'b1;
        @(negedge clk_i);
        reg_we_o = 1'b0;
        reg_wdata_o = ~d; // stale data must not be reused
    endtask
    // read data stands for the cycle after the request
    task automatic rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_re_o = 1'b1;
        @(negedge clk_i);
        reg_re_o = 1'b0;
        d = reg_rdata_i;
    endtask
    // result packed as valid, refused, data
    task automatic tab(input logic hi, input logic [11:0] pa,
                       input logic usr, output logic [9:0] r);
        @(negedge clk_i);
        tab_req_o = 1'b1;
        tab_high_o = hi;
        prog_addr_o = pa;
        user_read_o = usr;
        @(negedge clk_i);
        tab_req_o = 1'b0;
        r = {tab_valid_i, tab_refused_i, tab_data_i};
    endtask
endmodule

// ---- eal_top_tb_top.sv ----
`include "eal_cfg.svh"
`define EAL_CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("FAIL %0t got %h exp %h", $time, g, e); end end
module eal_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [8:0] ra;
    logic [7:0] rw, rr, td;
    logic we, re, tq, th, ur, tv, tr, pd, hold, ld, ue, le;
    logic [11:0] pa;
    logic [15:0] pdat = 16'h1986;
    logic [13:0] cl, ch;
    logic [1:0] ls, lvl, lvdl;
    logic low_voltage_reset, prot, xrst, lvda, wr_en, wi_en, lock;
    logic [7:0] b;
    logic [9:0] r;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    // ==========================================================
    // clock, time limit and closing report
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++; // hang guard
            end_sim();
        end
    end
    task automatic end_sim();
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ==========================================================
    // instances
    eal_cpu_model cpu (.clk_i(clk_i), .reg_rdata_i(rr), .tab_data_i(td),
        .tab_valid_i(tv), .tab_refused_i(tr), .reg_addr_o(ra),
        .reg_wdata_o(rw), .reg_we_o(we), .reg_re_o(re), .tab_req_o(tq),
        .tab_high_o(th), .prog_addr_o(pa), .user_read_o(ur));
    eal_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(ra),
        .reg_wdata_i(rw), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rr),
        .tab_req_i(tq), .tab_high_i(th), .prog_addr_i(pa),
        .prog_data_i(pdat), .user_read_i(ur), .tab_data_o(td),
        .tab_valid_o(tv), .tab_refused_o(tr), .prog_done_i(pd),
        .cpu_hold_o(hold), .cfg_load_i(ld), .cfg_low_i(cl),
        .cfg_high_i(ch), .user_erased_i(ue), .lib_erased_i(le),
        .lvd_sel_i(ls), .lvr_enable_o(low_voltage_reset), .code_protect_o(prot),
        .ext_reset_en_o(xrst), .lvr_level_o(lvl), .lvd_active_o(lvda),
        .lvd_level_o(lvdl), .wdt_run_en_o(wr_en), .wdt_idle_en_o(wi_en),
        .lib_lock_o(lock));
    // load both configuration words with one pulse
    task automatic cfg(input logic [13:0] h, input logic [13:0] l);
        @(negedge clk_i);
        ch = h;
        cl = l;
        ld = 1'b1;
        @(negedge clk_i);
        ld = 1'b0;
        @(negedge clk_i);
    endtask
    // ==========================================================
    // main sequence, inputs move on the falling edge
    initial begin
        {pd, ld, ue, le} = 4'h0;
        ch = 14'h0000;
        cl = 14'h0000;
        ls = 2'h1;
        repeat (20) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        `EAL_CHK(low_voltage_reset, 1'b1)
        cpu.rd(`EAL_ADDR_CONTROL, b);
        `EAL_CHK(b, 8'h00)
        cpu.rd(9'h100, b);
        `EAL_CHK(b, 8'h00)
        // enable, point at byte 23 through a set top bit
        cpu.wr(`EAL_ADDR_ACCESS_KEY, 8'hE2);
        cpu.wr(`EAL_ADDR_PTR_HIGH, 8'h00);
        cpu.wr(`EAL_ADDR_PTR_LOW, 8'hA3);
        cpu.wr(`EAL_ADDR_CONTROL, 8'h03);
        cpu.rd(`EAL_ADDR_CONTROL, b);
        `EAL_CHK(b, 8'h03)
        cpu.wr(`EAL_ADDR_LVR_OVERRIDE, 8'h37);
        @(negedge clk_i); // output flop follows the override one edge later
        `EAL_CHK(low_voltage_reset, 1'b0)
        cpu.wr(`EAL_ADDR_WRITE_DATA, 8'hA5);
        @(negedge clk_i);
        `EAL_CHK(hold, 1'b1)
        repeat (4) @(negedge clk_i);
        `EAL_CHK(hold, 1'b1)
        pd = 1'b1;
        for (int i = 0; i < 8 && hold !== 1'b0; i++) @(negedge clk_i);
        `EAL_CHK(hold, 1'b0)
        pd = 1'b0;
        cpu.rd(`EAL_ADDR_CONTROL, b);
        `EAL_CHK(b, 8'h03)
        cpu.tab(1'b0, 12'h000, 1'b0, r);
        `EAL_CHK(r, {2'b10, 8'hA5})
        cpu.wr(`EAL_ADDR_PTR_LOW, 8'h22);
        cpu.tab(1'b0, 12'h000, 1'b0, r);
        `EAL_CHK(r, {2'b10, 8'h00})
        // disable again; writes to the data register are then ignored
        cpu.wr(`EAL_ADDR_ACCESS_KEY, 8'h00);
        cpu.wr(`EAL_ADDR_LVR_OVERRIDE, 8'h00);
        @(negedge clk_i);
        `EAL_CHK(low_voltage_reset, 1'b1)
        cpu.wr(`EAL_ADDR_WRITE_DATA, 8'h5A);
        @(negedge clk_i);
        `EAL_CHK(hold, 1'b0)
        cpu.tab(1'b1, 12'h000, 1'b0, r);
        `EAL_CHK(r, {2'b10, 8'h19})
        // protect, pin reset, 2.4 V with detect, run-only watchdog, lock
        cfg(14'h3200, 14'h2200);
        `EAL_CHK({prot, xrst, lvl, lvda, lvdl}, 7'b1100101)
        `EAL_CHK({wr_en, wi_en, lock}, 3'b101)
        cpu.tab(1'b0, 12'hE00, 1'b0, r);
        `EAL_CHK(r[8:0], 9'h100)
        cpu.tab(1'b1, 12'hDFF, 1'b0, r);
        `EAL_CHK(r, {2'b10, 8'h19})
        cpu.tab(1'b0, 12'hDFF, 1'b1, r);
        `EAL_CHK(r[8:0], 9'h100)
        ls = 2'h2;
        cfg(14'h0000, 14'h3E00);
        `EAL_CHK(lvdl, 2'h3)
        `EAL_CHK({prot, lock}, 2'b11)
        cpu.tab(1'b0, 12'h700, 1'b0, r);
        `EAL_CHK(r[8:0], 9'h100)
        {ue, le} = 2'b11;
        cfg(14'h0F00, 14'h0000);
        `EAL_CHK({prot, lock, lvl, lvda}, 5'b00110)
        `EAL_CHK({wr_en, wi_en}, 2'b11)
        end_sim();
    end
endmodule
